// >>> ssp_fifo.sv
module ssp_fifo
#(
	parameter int WIDTH = 8,
	parameter int DEPTH = 32
)
(
	input  wire logic             clock_in,
	input  wire logic             reset_n_in,
	input  wire logic             in_valid_in,
	output logic                  in_ready_out,
	input  wire logic [WIDTH-1:0] in_data_in,
	output logic                  out_valid_out,
	input  wire logic             out_ready_in,
	output logic      [WIDTH-1:0] out_data_out
);

	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr_ff;
	logic [AW-1:0]    rd_ptr_ff;
	logic [AW:0]      count_ff;
	logic             push;
	logic             pop;

	assign push          = in_valid_in & in_ready_out;
	assign pop           = out_valid_out & out_ready_in;
	// flags decoded from a registered count, so they never glitch
	assign in_ready_out  = (count_ff != (AW+1)'(DEPTH));
	assign out_valid_out = (count_ff != '0);
	assign out_data_out  = mem[rd_ptr_ff];

	//////////////////////////////////////////////////////////////////
	// storage has no reset: only entries behind the pointers are read
	always_ff @(posedge clock_in)
	begin
		if (push)
			mem[wr_ptr_ff] <= in_data_in;
	end

	// pointers and fill level
	always_ff @(posedge clock_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
		begin
			wr_ptr_ff <= '0;
			rd_ptr_ff <= '0;
			count_ff  <= '0;
		end
		else
		begin
			if (push)
				wr_ptr_ff <= wr_ptr_ff + AW'(1);
			if (pop)
				rd_ptr_ff <= rd_ptr_ff + AW'(1);
			if (push && !pop)
				count_ff <= count_ff + (AW+1)'(1);
			else if (pop && !push)
				count_ff <= count_ff - (AW+1)'(1);
		end
	end

endmodule : ssp_fifo

// >>> ssp_peer.sv
module ssp_peer
(
	input  wire logic       sck_in,
	input  wire logic       so_in,
	input  wire logic       load_in,
	input  wire logic [7:0] tx_in,
	output logic            si_out,
	output logic      [7:0] rx_out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] tx_sh;

	initial
	begin
		si_out = 1'b0;
		rx_out = 8'h00;
		tx_sh = 8'h00;
	end

	// new frame byte; the line flips so stale data is never kind
	always @(posedge load_in)
	begin
		tx_sh = tx_in;
		si_out = ~si_out;
	end

	// msb first on falling clock; past the frame it shifts junk
	always @(negedge sck_in)
	begin
		si_out = tx_sh[7];
		tx_sh = {tx_sh[6:0], ~tx_sh[0]};
	end

	// device output taken on the rising clock
	always @(posedge sck_in)
		rx_out = {rx_out[6:0], so_in};
endmodule : ssp_peer

// >>> ssp_pkg.sv
package ssp_pkg;

	// serial clock source selected by the two clock select bits
	typedef enum logic [1:0]
	{
		SSP_CK_EXT     = 2'h0,
		SSP_CK_DIV16   = 2'h1,
		SSP_CK_DIV128  = 2'h2,
		SSP_CK_DIV1024 = 2'h3
	} ssp_clk_sel_t;

endpackage : ssp_pkg

// >>> ssp_regs.svh
`ifndef SSP_REGS_SVH
`define SSP_REGS_SVH

// register file addresses
`define SSP_ADDR_MODE       7'h02
`define SSP_ADDR_PINSEL     7'h0B
`define SSP_ADDR_DONE       7'h3B
// peripheral address of the shift register
`define SSP_PADDR_SHIFT     4'h1
// mode register fields
`define SSP_MODE_CKSEL_LO   0
`define SSP_MODE_CKSEL_HI   1
`define SSP_MODE_FLOAT      2
`define SSP_MODE_GO         3
// pin select register fields
`define SSP_PINSEL_ENABLE   0
`define SSP_PINSEL_TM1      3
// reset values
`define SSP_MODE_RESET      4'h0
`define SSP_PINSEL_RESET    4'h0
`define SSP_SHIFT_RESET     8'h00
// divider tap bits: clock toggles every half period
`define SSP_TAP_DIV16       4'h3
`define SSP_TAP_DIV128      4'h6
`define SSP_TAP_DIV1024     4'h9
`define SSP_DIV_W           10
`define SSP_BITS_PER_XFER   3'h7
`define SSP_FIFO_DEPTH      32
`define SSP_DATA_W          8

`endif

// >>> ssp_sva.sv
module ssp_sva
(
	input wire logic       clock_in,
	input wire logic       reset_n_in,
	input wire logic [6:0] rf_addr_in,
	input wire logic       rf_wr_in,
	input wire logic [3:0] rf_wdata_in,
	input wire logic [3:0] rf_rdata_out,
	input wire logic       port_sck_data_in,
	input wire logic       port_so_data_in,
	input wire logic       sck_out,
	input wire logic       sck_oe_n_out,
	input wire logic       so_out,
	input wire logic       so_oe_n_out,
	input wire logic       serial_done_request_out,
	input wire logic       timer1_out_select_out
);
	logic       en_ff;
	logic       flt_ff;
	logic [1:0] cks_ff;

	default clocking cb @(posedge clock_in);
	endclocking
	default disable iff (!reset_n_in);

	////////////////////////////////////////////////
	// shadow of the pin enable, so checks know the pin mode
	always_ff @(posedge clock_in or negedge reset_n_in)
		if (!reset_n_in)
			en_ff <= 1'b0;
		else if (rf_wr_in && rf_addr_in == 7'h0B)
			en_ff <= rf_wdata_in[0];

	// float and clock select only; go is skipped as it self-clears
	always_ff @(posedge clock_in or negedge reset_n_in)
		if (!reset_n_in)
			{flt_ff, cks_ff} <= 3'h0;
		else if (rf_wr_in && rf_addr_in == 7'h02)
			{flt_ff, cks_ff} <= rf_wdata_in[2:0];

	////////////////////////////////////////////////
	a_go_clears_done: assert property (
		rf_wr_in && rf_addr_in == 7'h02 && rf_wdata_in[3] |=> !serial_done_request_out)
		else $error("done flag survived a start");
	a_done_stays_set: assert property (
		serial_done_request_out && !(rf_wr_in && (rf_addr_in == 7'h02 || rf_addr_in == 7'h3B))
		|=> serial_done_request_out)
		else $error("done flag dropped on its own");
	a_tm1_follows_reg: assert property (
		rf_wr_in && rf_addr_in == 7'h0B ##1 !(rf_wr_in && rf_addr_in == 7'h0B)
		|=> timer1_out_select_out == $past(rf_wdata_in[3], 2))
		else $error("timer select pin differs from written bit");
	a_port_mode_pins: assert property (
		!en_ff |=> sck_out == $past(port_sck_data_in) && so_out == $past(port_so_data_in))
		else $error("pins do not follow port latch");
	a_float_no_drive: assert property (
		en_ff && flt_ff |=> so_oe_n_out)
		else $error("output driven while floating");
	a_int_clk_driven: assert property (
		en_ff && cks_ff != 2'h0 |=> !sck_oe_n_out)
		else $error("internal clock not driven out");
	a_ext_clk_input: assert property (
		en_ff && cks_ff == 2'h0 |=> sck_oe_n_out)
		else $error("clock pin driven in external mode");
	a_so_on_low_clk: assert property (
		$changed(so_out) && en_ff && $past(en_ff) && $past(en_ff, 2) && cks_ff == 2'h1
		|-> !sck_out)
		else $error("output bit changed while clock high");
	a_pinsel_zeros: assert property (
		$past(rf_addr_in) == 7'h0B |-> rf_rdata_out[2:1] == 2'h0)
		else $error("unused pin select bits read nonzero");

	c_done: cover property ($rose(serial_done_request_out));
	c_float: cover property (en_ff && flt_ff && $fell(sck_out));
	c_ext: cover property (en_ff && cks_ff == 2'h0 && $rose(serial_done_request_out));
endmodule : ssp_sva

// >>> ssp_tb.sv
`include "ssp_regs.svh"

module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic       clock_in;
	logic       reset_n_in;
	logic [6:0] rf_addr;
	logic       rf_wr;
	logic [3:0] rf_wdata;
	logic [3:0] rf_rdata;
	logic [3:0] per_addr;
	logic       put;
	logic [7:0] put_data;
	logic       put_ready;
	logic [7:0] get_data;
	logic [3:0] port_v;
	logic       ext_sck;
	logic       sck_o;
	logic       sck_oe_n;
	logic       so_o;
	logic       so_oe_n;
	logic       si;
	logic       done;
	logic       tm1;
	logic       peer_ld;
	logic [7:0] peer_tx;
	logic [7:0] peer_rx;
	logic [3:0] r4;
	logic [7:0] g;
	int         error_cnt;
	int         checked;
	// pull-up holds the output line high when nobody drives; the clock line falls back to ext_sck
	wire        sck_wire = !sck_oe_n ? sck_o : ext_sck;
	wire        so_wire = !so_oe_n ? so_o : 1'b1;

	ssp_top u_dut (.clock_in(clock_in), .reset_n_in(reset_n_in), .rf_addr_in(rf_addr),
		.rf_wr_in(rf_wr), .rf_wdata_in(rf_wdata), .rf_rdata_out(rf_rdata),
		.per_addr_in(per_addr), .put_in(put), .put_data_in(put_data),
		.put_ready_out(put_ready), .get_data_out(get_data), .port_sck_data_in(port_v[3]),
		.port_sck_oe_n_in(port_v[2]), .port_so_data_in(port_v[1]),
		.port_so_oe_n_in(port_v[0]), .sck_in(sck_wire), .sck_out(sck_o),
		.sck_oe_n_out(sck_oe_n), .so_out(so_o), .so_oe_n_out(so_oe_n), .si_in(si),
		.serial_done_request_out(done), .timer1_out_select_out(tm1));
	ssp_peer u_peer (.sck_in(sck_wire), .so_in(so_wire), .load_in(peer_ld),
		.tx_in(peer_tx), .si_out(si), .rx_out(peer_rx));

	////////////////////////////////////////////////
	// 250 MHz system clock
	initial
	begin
		clock_in = 1'b0;
		forever #2 clock_in = ~clock_in;
	end

	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		checked++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic wrap_up;
		$display("checks %0d errors %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : wrap_up

	task automatic wr(input logic [6:0] a, input logic [3:0] d);
		@(negedge clock_in);
		rf_addr = a;
		rf_wdata = d;
		rf_wr = 1'b1;
		@(negedge clock_in);
		rf_wr = 1'b0;
	endtask : wr

	// read data lands one edge after the address
	task automatic rd(input logic [6:0] a, output logic [3:0] d);
		@(negedge clock_in);
		rf_addr = a;
		@(negedge clock_in);
		d = rf_rdata;
	endtask : rd

	task automatic push(input logic [7:0] d, input logic [3:0] a);
		@(negedge clock_in);
		per_addr = a;
		put_data = d;
		put = 1'b1;
		@(negedge clock_in);
		put = 0;
	endtask : push

	task automatic get(output logic [7:0] d);
		@(negedge clock_in);
		per_addr = 4'h1;
		@(negedge clock_in);
		d = get_data;
	endtask : get

	// one frame; with fill the queue is stuffed until it refuses
	task automatic xfer(input logic [1:0] sel, input logic flt, input bit fill);
		logic [7:0] tx;
		logic [7:0] pb;
		logic [7:0] exp_q[$];
		int         n;
		tx = 8'($urandom);
		pb = 8'($urandom);
		push(tx, 4'h1);
		peer_tx = pb;
		peer_ld = 1'b1;
		repeat (3) @(negedge clock_in);
		peer_ld = 1'b0;
		wr(`SSP_ADDR_MODE, {1'b1, flt, sel});
		check("done at start", done, 1'b0);
		if (sel == 2'h0)
			repeat (8)
			begin
				#40 ext_sck = 1'b0;
				#40 ext_sck = 1'b1;
			end
		for (n = 0; n < 20000 && done !== 1'b1; n++)
		begin
			@(negedge clock_in);
			put = fill && !put && put_ready === 1'b1 && done !== 1'b1;
			if (put)
			begin
				put_data = 8'($urandom);
				exp_q.push_back(put_data);
			end
		end
		@(negedge clock_in);
		put = 1'b0;
		if (done !== 1'b1)
		begin
			error_cnt++;
			wrap_up();
		end
		if (fill)
			check("queue depth", 8'(exp_q.size()), 8'(`SSP_FIFO_DEPTH));
		rd(`SSP_ADDR_MODE, r4);
		check("mode after frame", r4, {1'b0, flt, sel});
		// a full queue drains one word per cycle once stopped
		repeat (70) @(negedge clock_in);
		get(g);
		// model: the newest queued word lands last, else the peer's byte stays
		check("received byte", g, (exp_q.size() != 0) ? exp_q[$] : pb);
		check("peer byte", peer_rx, flt ? 8'hFF : tx);
		if (!flt)
			check("output latch", so_o, tx[0]);
	endtask : xfer

	////////////////////////////////////////////////
	initial
	begin
		reset_n_in = 1'b0;
		{rf_addr, rf_wr, rf_wdata, per_addr, put, put_data} = '0;
		{port_v, peer_ld, peer_tx, error_cnt, checked} = '0;
		ext_sck = 1'b1;
		void'($urandom(32'h130213D3));
		repeat (10) @(negedge clock_in);
		check("reset pins", {so_o, so_oe_n, sck_oe_n}, 3'h3);
		reset_n_in = 1'b1;
		foreach (r4[i])
		begin
			rd(7'({i[1] ? 4'h7 : 4'h0, 3'h2} | (i[0] ? 7'h09 : 7'h00)), g[3:0]);
			check("reset value", g[3:0], 4'h0);
		end
		repeat (4)
		begin
			port_v = 4'($urandom);
			repeat (2) @(negedge clock_in);
			check("port pins", {sck_o, sck_oe_n, so_o, so_oe_n}, port_v);
		end
		wr(`SSP_ADDR_PINSEL, 4'hF);
		rd(`SSP_ADDR_PINSEL, r4);
		check("pin select", r4, 4'h9);
		check("timer select", tm1, 1'b1);
		wr(`SSP_ADDR_PINSEL, 4'h1);
		@(negedge clock_in);
		check("idle output", {so_o, so_oe_n}, 2'h0);
		check("timer select off", tm1, 1'b0);
		wr(7'h05, 4'hF);
		rd(7'h05, r4);
		check("unmapped", r4, 4'h0);
		peer_tx = 8'($urandom);
		push(peer_tx, 4'h1);
		push(~peer_tx, 4'h2);
		get(g);
		check("storage", g, peer_tx);
		xfer(2'h1, 1'b0, 1'b0);
		xfer(2'h2, 1'b0, 1'b0);
		xfer(2'h3, 1'b0, 1'b1);
		xfer(2'h0, 1'b0, 1'b0);
		xfer(2'h1, 1'b1, 1'b0);
		wr(7'h3B, 4'h0);
		rd(7'h3B, r4);
		check("done cleared", r4, 4'h0);
		wrap_up();
	end
endmodule : tb

bind ssp_top ssp_sva u_sva (.clock_in(clock_in), .reset_n_in(reset_n_in),
	.rf_addr_in(rf_addr_in), .rf_wr_in(rf_wr_in), .rf_wdata_in(rf_wdata_in),
	.rf_rdata_out(rf_rdata_out), .port_sck_data_in(port_sck_data_in),
	.port_so_data_in(port_so_data_in), .sck_out(sck_out), .sck_oe_n_out(sck_oe_n_out),
	.so_out(so_out), .so_oe_n_out(so_oe_n_out),
	.serial_done_request_out(serial_done_request_out),
	.timer1_out_select_out(timer1_out_select_out));

// >>> ssp_top.sv
`include "ssp_regs.svh"

module ssp_top
(
	input  wire logic       clock_in,
	input  wire logic       reset_n_in,
	// register file port, 4-bit data
	input  wire logic [6:0] rf_addr_in,
	input  wire logic       rf_wr_in,
	input  wire logic [3:0] rf_wdata_in,
	output logic      [3:0] rf_rdata_out,
	// peripheral port: writes through the transfer buffer, reads straight from the shift register
	input  wire logic [3:0] per_addr_in,
	input  wire logic       put_in,
	input  wire logic [7:0] put_data_in,
	output logic            put_ready_out,
	output logic      [7:0] get_data_out,
	// general port latch values used when the serial pins are ports
	input  wire logic       port_sck_data_in,
	input  wire logic       port_sck_oe_n_in,
	input  wire logic       port_so_data_in,
	input  wire logic       port_so_oe_n_in,
	// serial pins
	input  wire logic       sck_in,
	output logic            sck_out,
	output logic            sck_oe_n_out,
	output logic            so_out,
	output logic            so_oe_n_out,
	input  wire logic       si_in,
	// status and control
	output logic            serial_done_request_out,
	output logic            timer1_out_select_out
);

	//////////////////////////////////////////////////////////////////
	// declarations
	logic [3:0]                 mode_ff;
	logic [3:0]                 pinsel_ff;
	logic                       done_ff;
	logic [7:0]                 serial_shift_reg_ff;
	logic [2:0]                 bit_cnt_ff;
	logic [`SSP_DIV_W-1:0]      div_cnt_ff;
	logic                       int_prev_ff;
	logic                       sck_sync1_ff;
	logic                       sck_sync2_ff;
	logic                       sck_prev_ff;
	logic                       si_sync1_ff;
	logic                       si_sync2_ff;
	logic                       so_latch_ff;
	logic                       sck_out_ff;
	logic                       sck_oe_n_ff;
	logic                       so_out_ff;
	logic                       so_oe_n_ff;
	logic [3:0]                 rdata_ff;
	logic [7:0]                 get_data_ff;
	logic                       put_ready_ff;

	logic                       transfer_go;
	logic                       output_float_select;
	logic                       serial_pin_enable;
	ssp_pkg::ssp_clk_sel_t      clk_sel;
	logic                       wr_mode;
	logic                       wr_pinsel;
	logic                       wr_done;
	logic                       go_write;
	logic                       int_level;
	logic                       fall_stb;
	logic                       rise_stb;
	logic                       last_bit;
	logic                       fifo_in_valid;
	logic                       fifo_in_ready;
	logic                       fifo_out_valid;
	logic                       fifo_out_ready;
	logic [7:0]                 fifo_out_data;
	logic [3:0]                 tap;

	//////////////////////////////////////////////////////////////////
	// field decode
	assign transfer_go         = mode_ff[`SSP_MODE_GO];
	assign output_float_select = mode_ff[`SSP_MODE_FLOAT];
	assign serial_pin_enable   = pinsel_ff[`SSP_PINSEL_ENABLE];
	assign clk_sel             = ssp_pkg::ssp_clk_sel_t'({mode_ff[`SSP_MODE_CKSEL_HI],
	                                                     mode_ff[`SSP_MODE_CKSEL_LO]});

	// register file strobes
	assign wr_mode   = rf_wr_in && (rf_addr_in == `SSP_ADDR_MODE);
	assign wr_pinsel = rf_wr_in && (rf_addr_in == `SSP_ADDR_PINSEL);
	assign wr_done   = rf_wr_in && (rf_addr_in == `SSP_ADDR_DONE);
	assign go_write  = wr_mode && rf_wdata_in[`SSP_MODE_GO];

	//////////////////////////////////////////////////////////////////
	// pin synchronisers: only the second stage is looked at
	always_ff @(posedge clock_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
		begin
			sck_sync1_ff <= 1'b1;
			sck_sync2_ff <= 1'b1;
			sck_prev_ff  <= 1'b1;
			si_sync1_ff  <= 1'b0;
			si_sync2_ff  <= 1'b0;
		end
		else
		begin
			sck_sync1_ff <= sck_in;
			sck_sync2_ff <= sck_sync1_ff;
			sck_prev_ff  <= sck_sync2_ff;
			si_sync1_ff  <= si_in;
			si_sync2_ff  <= si_sync1_ff;
		end
	end

	//////////////////////////////////////////////////////////////////
	// internal serial clock: a divider tap, idling high between frames
	always_comb
	begin
		unique case (clk_sel)
			ssp_pkg::SSP_CK_DIV16:   tap = `SSP_TAP_DIV16;
			ssp_pkg::SSP_CK_DIV128:  tap = `SSP_TAP_DIV128;
			ssp_pkg::SSP_CK_DIV1024: tap = `SSP_TAP_DIV1024;
			ssp_pkg::SSP_CK_EXT:     tap = `SSP_TAP_DIV16;
		endcase
	end

	// low half of each period follows the high half, so a frame opens
	// with a falling edge
	assign int_level = ~div_cnt_ff[tap];

	// divider restarts on every start so the first half period is whole
	always_ff @(posedge clock_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
			div_cnt_ff <= '0;
		else if (!transfer_go || go_write)
			div_cnt_ff <= '0;
		else
			div_cnt_ff <= div_cnt_ff + `SSP_DIV_W'(1);
	end

	// previous internal level for edge strobes
	always_ff @(posedge clock_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
			int_prev_ff <= 1'b1;
		else if (!transfer_go)
			int_prev_ff <= 1'b1;
		else
			int_prev_ff <= int_level;
	end

	// edge strobes from whichever source is selected; none while stopped
	always_comb
	begin
		fall_stb = 1'b0;
		rise_stb = 1'b0;
		if (transfer_go && serial_pin_enable)
		begin
			if (clk_sel == ssp_pkg::SSP_CK_EXT)
			begin
				fall_stb = sck_prev_ff & ~sck_sync2_ff;
				rise_stb = ~sck_prev_ff & sck_sync2_ff;
			end
			else
			begin
				fall_stb = int_prev_ff & ~int_level;
				rise_stb = ~int_prev_ff & int_level;
			end
		end
	end

	assign last_bit = rise_stb && (bit_cnt_ff == `SSP_BITS_PER_XFER);

	//////////////////////////////////////////////////////////////////
	// serial clock counter
	always_ff @(posedge clock_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
			bit_cnt_ff <= 3'h0;
		else if (go_write)
			bit_cnt_ff <= 3'h0;
		else if (rise_stb)
			bit_cnt_ff <= bit_cnt_ff + 3'h1;
	end

	// mode register; the go bit clears itself after the eighth clock
	always_ff @(posedge clock_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
			mode_ff <= `SSP_MODE_RESET;
		else if (wr_mode)
			mode_ff <= rf_wdata_in;
		else if (last_bit)
			mode_ff[`SSP_MODE_GO] <= 1'b0;
	end

	// pin function register
	always_ff @(posedge clock_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
			pinsel_ff <= `SSP_PINSEL_RESET;
		else if (wr_pinsel)
		begin
			pinsel_ff[`SSP_PINSEL_ENABLE] <= rf_wdata_in[`SSP_PINSEL_ENABLE];
			pinsel_ff[`SSP_PINSEL_TM1]    <= rf_wdata_in[`SSP_PINSEL_TM1];
		end
	end

	// done request: completion beats a same-cycle software clear
	always_ff @(posedge clock_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
			done_ff <= 1'b0;
		else if (last_bit)
			done_ff <= 1'b1;
		else if (go_write)
			done_ff <= 1'b0;
		else if (wr_done)
			done_ff <= rf_wdata_in[0];
	end

	//////////////////////////////////////////////////////////////////
	// queued writes to the shift register: drained only while stopped, one word per cycle,
	// so software can stack words during a transfer but only the newest one stays loaded
	assign fifo_in_valid  = put_in && (per_addr_in == `SSP_PADDR_SHIFT);
	assign fifo_out_ready = !transfer_go && !go_write;

	ssp_fifo
	#(
		.WIDTH (`SSP_DATA_W),
		.DEPTH (`SSP_FIFO_DEPTH)
	)
	u_fifo
	(
		.clock_in      (clock_in),
		.reset_n_in    (reset_n_in),
		.in_valid_in   (fifo_in_valid),
		.in_ready_out  (fifo_in_ready),
		.in_data_in    (put_data_in),
		.out_valid_out (fifo_out_valid),
		.out_ready_in  (fifo_out_ready),
		.out_data_out  (fifo_out_data)
	);

	// shift register: plain storage while stopped, shifts on rising edges
	always_ff @(posedge clock_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
			serial_shift_reg_ff <= `SSP_SHIFT_RESET;
		else if (rise_stb)
			serial_shift_reg_ff <= {serial_shift_reg_ff[6:0], si_sync2_ff};
		else if (fifo_out_valid && fifo_out_ready)
			serial_shift_reg_ff <= fifo_out_data;
	end

	// output latch: separate from the port latch, holds the last bit sent
	always_ff @(posedge clock_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
			so_latch_ff <= 1'b0;
		else if (fall_stb && !output_float_select)
			so_latch_ff <= serial_shift_reg_ff[7];
	end

	//////////////////////////////////////////////////////////////////
	// pin drivers; an enable of 0 means the pin is driven
	always_ff @(posedge clock_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
		begin
			sck_out_ff  <= 1'b1;
			sck_oe_n_ff <= 1'b1;
			so_out_ff   <= 1'b0;
			so_oe_n_ff  <= 1'b1;
		end
		else if (serial_pin_enable)
		begin
			if (clk_sel == ssp_pkg::SSP_CK_EXT)
			begin
				sck_out_ff  <= 1'b1;
				sck_oe_n_ff <= 1'b1;
			end
			else
			begin
				sck_out_ff  <= transfer_go ? int_level : 1'b1;
				sck_oe_n_ff <= 1'b0;
			end
			// float leaves the output pin to the port as an input
			so_out_ff  <= so_latch_ff;
			so_oe_n_ff <= output_float_select;
		end
		else
		begin
			sck_out_ff  <= port_sck_data_in;
			sck_oe_n_ff <= port_sck_oe_n_in;
			so_out_ff   <= port_so_data_in;
			so_oe_n_ff  <= port_so_oe_n_in;
		end
	end

	//////////////////////////////////////////////////////////////////
	// read paths, one cycle behind the address
	always_ff @(posedge clock_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
			rdata_ff <= 4'h0;
		else if (rf_addr_in == `SSP_ADDR_MODE)
			rdata_ff <= mode_ff;
		else if (rf_addr_in == `SSP_ADDR_PINSEL)
			rdata_ff <= pinsel_ff;
		else if (rf_addr_in == `SSP_ADDR_DONE)
			rdata_ff <= {3'h0, done_ff};
		else
			rdata_ff <= 4'h0;
	end

	// shift register read; every other address reads all eight bits zero
	always_ff @(posedge clock_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
			get_data_ff <= 8'h00;
		else if (per_addr_in == `SSP_PADDR_SHIFT)
			get_data_ff <= serial_shift_reg_ff;
		else
			get_data_ff <= 8'h00;
	end

	// registered copy of queue space for the caller
	always_ff @(posedge clock_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
			put_ready_ff <= 1'b0;
		else
			put_ready_ff <= fifo_in_ready;
	end

	//////////////////////////////////////////////////////////////////
	// outputs
	assign rf_rdata_out            = rdata_ff;
	assign get_data_out            = get_data_ff;
	assign put_ready_out           = put_ready_ff;
	assign sck_out                 = sck_out_ff;
	assign sck_oe_n_out            = sck_oe_n_ff;
	assign so_out                  = so_out_ff;
	assign so_oe_n_out             = so_oe_n_ff;
	assign serial_done_request_out = done_ff;
	assign timer1_out_select_out   = pinsel_ff[`SSP_PINSEL_TM1];

endmodule : ssp_top
